/* rtl/acq_seq_pkg.sv */
// constants, settings layout and port carriers of the acquisition sequencer
// assumes a single 200 MHz core clock shared with the converter and nv store
package acq_seq_pkg;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_TIME_NS = 1000;
  localparam int TICK_CYC = US_TIME_NS / CLK_PERIOD_NS;
  localparam int DEAD_TIME_NS = 1600;
  localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_PS = 42700000;
  localparam int CONV_CYC_DEF = CONV_TIME_PS / (CLK_PERIOD_NS * 1000);
  localparam int TRIG_MARGIN_NS = 3200;
  localparam int TICK_W = 8;
  localparam int DEAD_W = 9;
  localparam int CONV_W = 16;
  // -------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------
  localparam int MAX_HEADS = 8;
  localparam int HEAD_W = 3;
  localparam int RANGE_W = 3;
  localparam int PERIOD_W = 16;
  localparam int ADC_W = 16;
  localparam int ACC_W = ADC_W + 2;
  localparam int CHAN_W = 8;
  localparam int ADDR_W = 8;
  // -------------------------------------------------------------------
  // register map and fields
  // -------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_HEADS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RANGE = 8'h20;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_HIGH = 1;
  localparam int CTRL_TRIG = 2;
  localparam int CTRL_SUB = 3;
  localparam int CTRL_SAVE = 5;
  localparam int RNG_LO = 0;
  localparam int RNG_HI = 4;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h03e8;
  localparam logic [3:0] HEADS_RST = 4'h1;
  localparam logic [1:0] SUB_1 = 2'h0;
  localparam logic [1:0] SUB_2 = 2'h1;
  localparam logic [1:0] SUB_4 = 2'h2;

  typedef logic [RANGE_W-1:0] range_t;
  typedef struct packed {
    logic run;
    logic high_energy;
    logic trig_mode;
    logic [1:0] sub_mode;
    logic [PERIOD_W-1:0] period;
    logic [3:0] heads;
    range_t [MAX_HEADS-1:0] range_hi;
    range_t [MAX_HEADS-1:0] range_lo;
  } settings_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [ADC_W-1:0] data;
  } adc_t;
  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [ACC_W-1:0] data;
  } out_t;
  typedef enum logic [3:0] {
    S_LOAD = 4'h1,
    S_IDLE = 4'h2,
    S_INTEG = 4'h4,
    S_DEAD = 4'h8
  } seq_state_t;

  // index of the last sub-sample of a sum
  function automatic logic [1:0] sub_last(input logic [1:0] m);
    case (m)
      SUB_2: sub_last = 2'h1;
      SUB_4: sub_last = 2'h3;
      default: sub_last = 2'h0;
    endcase
  endfunction

  function automatic logic [3:0] fix_heads(input logic [3:0] h);
    if (h == 4'h0) begin
      fix_heads = 4'h1;
    end else if (h > 4'(MAX_HEADS)) begin
      fix_heads = 4'(MAX_HEADS);
    end else begin
      fix_heads = h;
    end
  endfunction

  function automatic logic range_hit(input logic [ADDR_W-1:0] a);
    range_hit = (a[7:5] == REG_RANGE[7:5]) && (a[1:0] == 2'h0);
  endfunction
endpackage

/* rtl/xray_acq_sequencer.sv */
// integration, dead time and conversion sequencer with sub-sample summing
// assumes converter samples, nv store and register port share core_clk;
// only the external trigger is asynchronous
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module xray_acq_sequencer #(
  parameter int CONV_CYC = acq_seq_pkg::CONV_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire acq_seq_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic ext_trig,
  input wire acq_seq_pkg::settings_t nv_load_data,
  input wire logic nv_load_valid,
  output logic nv_load_req,
  output acq_seq_pkg::settings_t nv_image,
  output logic nv_save,
  output logic integrate,
  output logic conv_start,
  output logic [acq_seq_pkg::HEAD_W-1:0] head_sel,
  output acq_seq_pkg::range_t [acq_seq_pkg::MAX_HEADS-1:0] head_range,
  input wire acq_seq_pkg::adc_t adc,
  output acq_seq_pkg::out_t sample_out
);
  import acq_seq_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    settings_t set;
    logic [TICK_W-1:0] tick;
    logic [PERIOD_W-1:0] us;
    logic [DEAD_W-1:0] dead;
    logic [CONV_W-1:0] conv_cnt;
    logic [HEAD_W-1:0] head;
    logic busy;
    logic [1:0] frame;
    logic [1:0] conv_frame;
    logic [2:0] trig_sync;
    logic trig_lvl;
    logic [31:0] rdata;
    logic save;
    logic integ;
    range_t [MAX_HEADS-1:0] rng_out;
    out_t out;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic [ACC_W-1:0] acc_mem [0:(2**CHAN_W)-1];
  logic [ACC_W-1:0] acc_sum;
  logic acc_last;
  logic trig_edge;
  logic cont;
  logic [31:0] int_cyc;
  logic [31:0] min_cyc;
  logic [PERIOD_W-1:0] period_eff;
  logic [HEAD_W-1:0] ridx;

  // -------------------------------------------------------------------
  // derived terms
  // -------------------------------------------------------------------
  always_comb begin
    period_eff = (r.set.period == '0) ? PERIOD_W'(1) : r.set.period;
    int_cyc = 32'(period_eff) * 32'(TICK_CYC);
    // continuous only when the dead interval plus conversion of every board fits the period
    min_cyc = 32'(DEAD_CYC) + 32'(r.set.heads) * 32'(CONV_CYC);
    cont = (int_cyc >= min_cyc);
    // only the agreeing second and third stages count as a change
    trig_edge = (r.trig_sync[1] == r.trig_sync[2]) && r.trig_sync[2] && !r.trig_lvl;
    acc_last = (r.conv_frame >= sub_last(r.set.sub_mode));
    // sum is two bits wider than a sample so four never overflow
    acc_sum = ((r.conv_frame == 2'h0) ? ACC_W'(0) : acc_mem[adc.chan])
      + ACC_W'(adc.data);
    ridx = bus.addr[HEAD_W+1:2];
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.save = 1'b0;
    next_r.rdata = '0;
    next_r.out.valid = 1'b0;
    next_r.trig_sync = {r.trig_sync[1:0], ext_trig};
    if (r.trig_sync[1] == r.trig_sync[2]) begin
      next_r.trig_lvl = r.trig_sync[2];
    end

    if (bus.wr) begin
      case (bus.addr)
        REG_CTRL: begin
          next_r.set.run = bus.wdata[CTRL_RUN];
          next_r.set.high_energy = bus.wdata[CTRL_HIGH];
          next_r.set.trig_mode = bus.wdata[CTRL_TRIG];
          next_r.set.sub_mode = bus.wdata[CTRL_SUB+:2];
          next_r.save = bus.wdata[CTRL_SAVE];
        end
        REG_PERIOD: next_r.set.period = bus.wdata[PERIOD_W-1:0];
        REG_HEADS: next_r.set.heads = fix_heads(bus.wdata[3:0]);
        default: begin
          if (range_hit(bus.addr)) begin
            next_r.set.range_lo[ridx] = bus.wdata[RNG_LO+:RANGE_W];
            next_r.set.range_hi[ridx] = bus.wdata[RNG_HI+:RANGE_W];
          end
        end
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: next_r.rdata = 32'({r.set.sub_mode, r.set.trig_mode,
          r.set.high_energy, r.set.run});
        REG_PERIOD: next_r.rdata = 32'(r.set.period);
        REG_HEADS: next_r.rdata = 32'(r.set.heads);
        REG_STATUS: next_r.rdata = 32'({r.frame, r.head, r.busy, cont, r.st});
        default: begin
          if (range_hit(bus.addr)) begin
            next_r.rdata = 32'({1'b0, r.set.range_hi[ridx], 1'b0, r.set.range_lo[ridx]});
          end
        end
      endcase
    end

    // conversion walks the head boards one slot each
    if (r.busy) begin
      if (r.conv_cnt == CONV_W'(CONV_CYC - 1)) begin
        next_r.conv_cnt = '0;
        if (r.head == HEAD_W'(r.set.heads - 4'h1)) begin
          next_r.busy = 1'b0;
        end else begin
          next_r.head = r.head + HEAD_W'(1);
        end
      end else begin
        next_r.conv_cnt = r.conv_cnt + CONV_W'(1);
      end
    end

    case (r.st)
      S_LOAD: begin
        if (nv_load_valid) begin
          next_r.set = nv_load_data;
          next_r.set.heads = fix_heads(nv_load_data.heads);
          next_r.st = S_IDLE;
        end
      end
      S_IDLE: begin
        if (r.set.run && (!r.set.trig_mode || trig_edge)) begin
          next_r.st = S_INTEG;
          next_r.tick = '0;
          next_r.us = '0;
          next_r.integ = 1'b1;
          next_r.rng_out = r.set.high_energy ? r.set.range_hi : r.set.range_lo;
        end
      end
      S_INTEG: begin
        if (r.tick == TICK_W'(TICK_CYC - 1)) begin
          next_r.tick = '0;
          next_r.us = r.us + PERIOD_W'(1);
          if (r.us + PERIOD_W'(1) >= period_eff) begin
            next_r.st = S_DEAD;
            next_r.dead = '0;
            next_r.integ = 1'b0;
            // hand the finished frame to conversion
            next_r.busy = 1'b1;
            next_r.head = '0;
            next_r.conv_cnt = '0;
            next_r.conv_frame = r.frame;
            next_r.frame = (r.frame >= sub_last(r.set.sub_mode)) ? 2'h0
              : r.frame + 2'h1;
          end
        end else begin
          next_r.tick = r.tick + TICK_W'(1);
        end
      end
      S_DEAD: begin
        if (r.dead < DEAD_W'(DEAD_CYC - 1)) begin
          next_r.dead = r.dead + DEAD_W'(1);
        end else if (cont || !r.busy) begin
          if (r.set.run && !r.set.trig_mode) begin
            next_r.st = S_INTEG;
            next_r.tick = '0;
            next_r.us = '0;
            next_r.integ = 1'b1;
            next_r.rng_out = r.set.high_energy ? r.set.range_hi : r.set.range_lo;
          end else begin
            // triggered runs wait in idle for the next edge
            next_r.st = S_IDLE;
          end
        end
      end
      default: next_r.st = S_IDLE;
    endcase

    if (adc.valid) begin
      next_r.out.chan = adc.chan;
      next_r.out.data = acc_sum;
      next_r.out.valid = acc_last;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
      r.st <= S_LOAD;
      r.set.period <= PERIOD_RST;
      r.set.heads <= HEADS_RST;
    end else begin
      r <= next_r;
    end
  end

  // partial sums per channel; no reset needed as frame 0 ignores them
  always_ff @(posedge core_clk) begin
    if (adc.valid && !acc_last) begin
      acc_mem[adc.chan] <= acc_sum;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign rdata = r.rdata;
  assign nv_load_req = (r.st == S_LOAD);
  assign nv_image = r.set;
  assign nv_save = r.save;
  assign integrate = r.integ;
  assign conv_start = r.busy && (r.conv_cnt == '0);
  assign head_sel = r.head;
  assign head_range = r.rng_out;
  assign sample_out = r.out;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_DEAD_LEN: assert property (
    ($past(r.st) == S_DEAD && r.st != S_DEAD) |-> $past(r.dead) == DEAD_W'(DEAD_CYC - 1))
    else $error("dead interval shorter than 1.6 us");
  AST_RANGE_WR: assert property (
    (bus.wr && range_hit(bus.addr)) |=>
      r.set.range_hi[$past(ridx)] == $past(bus.wdata[RNG_HI+:RANGE_W]))
    else $error("range setting not stored");
  AST_RANGE_APPLY: assert property (
    (r.st == S_INTEG && $past(r.st) != S_INTEG) |->
      r.rng_out == ($past(r.set.high_energy) ? $past(r.set.range_hi) : $past(r.set.range_lo)))
    else $error("wrong energy range applied");
  AST_SINGLE_OUT: assert property (
    (adc.valid && r.set.sub_mode == SUB_1 && r.conv_frame == 2'h0) |=>
      sample_out.valid && sample_out.data == ACC_W'($past(adc.data)))
    else $error("single sample not passed through");
  AST_US_STEP: assert property (
    (r.st == S_INTEG && r.tick == TICK_W'(TICK_CYC - 1)) |=>
      r.us == $past(r.us) + PERIOD_W'(1))
    else $error("period counter missed a microsecond");
  AST_CONV_SLOT: assert property (
    (r.busy && $past(r.busy) && r.head != $past(r.head)) |->
      $past(r.conv_cnt) == CONV_W'(CONV_CYC - 1))
    else $error("head board slot cut short");
  AST_OVERLAP: assert property (
    (r.st == S_INTEG && r.busy) |-> cont)
    else $error("conversion overlaps integration in non-continuous mode");
  AST_NONCONT_WAIT: assert property (
    (r.st == S_DEAD && !cont && r.busy) |=> r.st == S_DEAD)
    else $error("integration started before conversion ended");
  AST_SAVE: assert property (
    (bus.wr && bus.addr == REG_CTRL && bus.wdata[CTRL_SAVE]) |=>
      nv_save && nv_image.run == $past(bus.wdata[CTRL_RUN]))
    else $error("save pulse or image wrong");
  AST_RESTART: assert property (
    (r.st == S_INTEG && $past(r.st) == S_DEAD) |-> r.us == '0 && r.tick == '0)
    else $error("period counter not restarted");

  // -------------------------------------------------------------------
  // settings, handover and output housekeeping
  // -------------------------------------------------------------------
  // read data must not linger, the bus has no separate valid
  AST_RDATA_IDLE: assert property (
    !$past(bus.rd) |-> rdata == '0)
    else $error("read data present without a read");
  AST_LOAD_HOLD: assert property (
    (r.st == S_LOAD && !nv_load_valid) |=> r.st == S_LOAD)
    else $error("left load state without a stored image");
  AST_LOAD_TAKE: assert property (
    (r.st == S_LOAD && nv_load_valid) |=>
      r.st == S_IDLE && nv_image.period == $past(nv_load_data.period))
    else $error("stored image not taken at power-on");
  // a zero or oversized board count would end the slot walk on the wrong board
  AST_HEADS_RANGE: assert property (
    nv_image.heads != 4'h0 && nv_image.heads <= 4'(MAX_HEADS))
    else $error("head board count outside 1 to 8");
  AST_INTEG_LEVEL: assert property (
    integrate == (r.st == S_INTEG))
    else $error("integrate level disagrees with state");
  AST_TICK_WRAP: assert property (
    (r.st == S_INTEG) |-> r.tick < TICK_W'(TICK_CYC))
    else $error("microsecond tick overran");
  AST_DEAD_ENTRY: assert property (
    ($past(r.st) == S_INTEG && r.st == S_DEAD) |->
      r.dead == '0 && r.busy)
    else $error("finished frame not handed to conversion");
  AST_CONV_FIRST: assert property (
    (r.st == S_DEAD && $past(r.st) == S_INTEG) |->
      conv_start && head_sel == '0)
    else $error("conversion did not open on the first head board");
  AST_HEAD_BOUND: assert property (
    r.busy |-> 4'(r.head) < r.set.heads)
    else $error("conversion slot beyond the last head board");
  // triggered runs must not free-run between edges
  AST_TRIG_WAIT: assert property (
    (r.st == S_IDLE && r.set.trig_mode && !trig_edge) |=>
      r.st == S_IDLE)
    else $error("integration started without a trigger edge");
  AST_SAVE_PULSE: assert property (
    nv_save |->
      $past(bus.wr) && $past(bus.addr) == REG_CTRL)
    else $error("save pulse without a control write");
  AST_SUM_OUT: assert property (
    sample_out.valid |-> $past(adc.valid))
    else $error("sum output without a converted sample");
  AST_RANGE_STABLE: assert property (
    (r.st == S_INTEG && $past(r.st) == S_INTEG) |->
      $stable(head_range))
    else $error("range changed inside an integration");
endmodule

/* tb/adc_head_model.sv */
// behavioural head boards plus converter: one sample per conversion slot
// assumes conv_start and head_sel come from the sequencer on core_clk
`timescale 1ns/1ps
module adc_head_model #(
  parameter int DLY = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [acq_seq_pkg::HEAD_W-1:0] head_sel,
  output acq_seq_pkg::adc_t adc
);
  import acq_seq_pkg::*;
  int cnt;
  logic [HEAD_W-1:0] head;
  // full-scale samples so a four-way sum exercises the top bits
  always @(posedge core_clk) begin
    adc.valid <= 1'b0;
    adc.data <= ~adc.data;
    if (rst) begin
      cnt <= 0;
      adc <= '0;
    end else if (conv_start) begin
      cnt <= DLY;
      head <= head_sel;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        adc <= '{valid: 1'b1, chan: {5'h0, head}, data: 16'hffff};
      end
    end
  end
endmodule

/* tb/tb_xray_acquisition_sequencer.sv */
// register-level tests of the acquisition sequencer
// assumes converter answers come from adc_head_model, nv store is the bench
`timescale 1ns/1ps
module tb_xray_acquisition_sequencer;
  import acq_seq_pkg::*;
  localparam int CONV = 50;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_t bus = '0;
  logic [31:0] rdata, d;
  logic ext_trig = 1'b0;
  settings_t nv_load_data;
  logic nv_load_valid = 1'b0;
  logic nv_load_req, nv_save, integrate, conv_start, ovl = 1'b0;
  settings_t nv_image, saved = '0;
  logic [HEAD_W-1:0] head_sel;
  range_t [MAX_HEADS-1:0] head_range;
  adc_t adc;
  out_t sample_out;
  int failures = 0, n_tests = 0, n, gap = 0, min_gap = 99999;

  always #2.5 core_clk = ~core_clk;

  xray_acq_sequencer #(.CONV_CYC(CONV)) u_xray_acq_sequencer (.core_clk(core_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .ext_trig(ext_trig), .nv_load_data(nv_load_data),
    .nv_load_valid(nv_load_valid), .nv_load_req(nv_load_req), .nv_image(nv_image),
    .nv_save(nv_save), .integrate(integrate), .conv_start(conv_start), .head_sel(head_sel),
    .head_range(head_range), .adc(adc), .sample_out(sample_out));
  adc_head_model u_adc_head_model (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
    .head_sel(head_sel), .adc(adc));

  // -------------------------------------------------------------------
  // monitors
  // -------------------------------------------------------------------
  always @(posedge core_clk) begin
    gap <= conv_start ? 1 : gap + 1;
    if (conv_start && gap < min_gap) min_gap <= gap;
    if (integrate && conv_start) ovl <= 1'b1;
    if (nv_save) saved <= nv_image;
  end

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    tick();
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    tick();
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    tick();
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    tick();
    v = rdata;
    bus <= '0;
  endtask
  // bounded wait for integrate to reach a level, returning the cycles spent
  task automatic wait_int(input logic v, output int c);
    c = 0;
    while (integrate !== v && c < 8000) begin
      tick();
      c++;
    end
    if (c >= 8000) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic wait_out();
    n = 0;
    tick();
    while (!(sample_out.valid === 1'b1 && sample_out.chan === 8'h0) && n < 9000) begin
      tick();
      n++;
    end
    if (n >= 9000) begin
      failures++;
      end_of_test();
    end
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    nv_load_data = '0;
    nv_load_data.period = 16'h0005;
    nv_load_data.heads = 4'h8;
    repeat (20) tick();
    rst <= 1'b0;
    repeat (3) tick();
    nv_load_valid <= 1'b1;
    tick();
    nv_load_valid <= 1'b0;
    tick();
    chk({31'h0, nv_load_req}, 32'h0);
    rd(REG_PERIOD, d); chk(d, 32'h5);
    rd(8'h10, d); chk(d, 32'h0);
    wr(REG_RANGE, 32'h53);
    wr(8'h3c, 32'h07);
    rd(8'h3c, d); chk(d, 32'h07);
    wr(REG_CTRL, 32'h3);
    wait_int(1'b1, n);
    chk({29'h0, head_range[0]}, 32'h5);
    chk({29'h0, head_range[7]}, 32'h0);
    wait_int(1'b0, n); chk(n, 32'd1000);
    wait_int(1'b1, n); chk(n, 32'd320);
    chk({29'h0, head_range[0]}, 32'h5);
    // the last head slot of the old frame opens 30 cycles into the new integration
    repeat (40) tick();
    chk({31'h0, ovl}, 32'h1);
    chk(min_gap, CONV);
    wr(REG_CTRL, 32'h1);
    wait_int(1'b0, n);
    wait_int(1'b1, n);
    chk({29'h0, head_range[0]}, 32'h3);
    chk({29'h0, head_range[7]}, 32'h7);
    wait_int(1'b0, n);
    // shorten only while in the dead interval, so no running integration sees the switch
    wr(REG_PERIOD, 32'h0001);
    wait_int(1'b1, n);
    wait_int(1'b0, n); chk(n, 32'd200);
    wait_int(1'b1, n);
    chk({31'h0, n >= 8 * CONV && n <= 8 * CONV + 4}, 32'h1);
    wr(REG_CTRL, 32'h09);
    wait_out();
    wait_out(); chk({14'h0, sample_out.data}, 32'h1fffe);
    wr(REG_CTRL, 32'h11);
    wait_out();
    wait_out(); chk({14'h0, sample_out.data}, 32'h3fffc);
    wr(REG_CTRL, 32'h21);
    repeat (3) tick();
    chk({16'h0, saved.period}, 32'h1);
    chk({28'h0, saved.heads}, 32'h8);
    wr(REG_CTRL, 32'h5);
    wait_int(1'b0, n);
    repeat (900) tick();
    chk({31'h0, integrate}, 32'h0);
    ext_trig <= 1'b1;
    tick();
    wait_int(1'b1, n); chk({31'h0, n <= 6}, 32'h1);
    ext_trig <= 1'b0;
    end_of_test();
  end
endmodule
